// ---- hw/dif_decoder.sv ----
// Multi-function input terminal decoder for the drive control core
// Overview of operation
// [R01] Coast-stop input active disables the output stage at once.
// [R02] Run-pause ramps to stop; release restores the previous running state.
// [R03] Normally-open external fault raises code 15 with configured protection.
// [R04] Four step inputs form a 4-bit index, terminal 1 least significant.
// [R05] Multi-step source scales step values so 100 % is maximum frequency.
// [R06] Two ramp inputs form a 2-bit ramp pair index.
// [R07] Up/down clear drops all increments and returns to preset frequency.
// [R08] Source switch 1 active takes run commands from the keypad.
// [R09] Ramp inhibit holds output frequency, but a stop command still acts.
// [R10] PID pause suspends regulation and keeps the present frequency.
// [R11] Torque inhibit forces speed control mode.
// [R12] Normally-closed external fault raises code 15 and stops the motor.
// [R13] Frequency lock ignores every set frequency change from any source.
// [R14] Source switch 2 active takes run commands from the link when the configured source is the terminals.
// [R15] Integral hold freezes the PID integral term only.
// [R16] Main or auxiliary preset override uses the preset frequency instead.
// [R17] Motor select picks parameter set and ramp pair one or two.
// [R18] With terminal gain switching, the input picks the PID gain triple.
// [R19] User faults one and two raise codes 27 and 28.
// [R20] Speed/torque switch selects the opposite of the configured mode.
// [R21] External stop 2 ramps down using the fourth deceleration time.
// [R22] Decelerate-brake ramps to DC start frequency, then DC brakes.
// [R23] Wire swap turns two-wire mode 1 into three-wire mode 1.
// [R24] Inputs count as active after the filter time, default 10 ms.
// [R25] Function code zero or reserved codes cause no action.
`timescale 1ns/1ps
module dif_decoder
  import dif_pkg::*;
#(
  parameter int N             = 7,
  parameter int FREQ_W        = 16,
  parameter int CYCLES_PER_MS = DIF_CYCLES_PER_MS
)(
  // Clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   SRST,
  // Terminal pins and their function assignment
  input  wire logic [N-1:0]           DIGITAL_INPUT_TERMINAL,
  input  wire logic [N-1:0][5:0]      FUNC_SEL,
  input  wire logic [9:0]             INPUT_FILTER_TIME,
  // Configuration
  input  wire logic [1:0]             CMD_SOURCE_SETTING,
  input  wire logic [1:0]             TERMINAL_COMMAND_MODE,
  input  wire logic                   CONTROL_MODE_SETTING,
  input  wire logic                   PID_DIRECTION_SETTING,
  input  wire logic [1:0]             PID_GAIN_SWITCH_SOURCE,
  input  wire logic [1:0]             EXT_FAULT_RESPONSE,
  input  wire logic [1:0]             USER_FAULT_RESPONSE_SETTING,
  input  wire logic                   FREQ_SRC_MULTISTEP,
  input  wire logic [FREQ_W-1:0]      MAXIMUM_FREQUENCY_SETTING,
  input  wire logic [FREQ_W-1:0]      PRESET_FREQUENCY_SETTING,
  input  wire logic [FREQ_W-1:0]      DC_START_FREQ,
  // Step reference store
  input  wire logic                   STEP_WR_EN,
  input  wire logic [3:0]             STEP_WR_ADDR,
  input  wire logic [15:0]            STEP_WR_DATA,
  // Drive state and frequency change requests
  input  wire logic                   RUNNING,
  input  wire logic                   STOP_CMD,
  input  wire logic [FREQ_W-1:0]      OUT_FREQ,
  input  wire logic                   FREQ_MOD_REQ,
  input  wire logic [FREQ_W-1:0]      FREQ_MOD_VALUE,
  // Stop and run control
  output logic                        OUTPUT_DISABLE,
  output logic                        PAUSE_STOP_REQ,
  output logic                        RESUME_REQ,
  output logic                        STOP_DECEL_REQ,
  output logic                        BRAKE_DECEL_REQ,
  output logic                        DC_BRAKE_ON,
  // Faults
  output logic                        FAULT_RAISE,
  output dif_fault_s                  FAULT,
  // Reference and ramp
  output logic [3:0]                  STEP_INDEX,
  output logic [FREQ_W-1:0]           STEP_FREQ,
  output logic [1:0]                  RAMP_SEL,
  output logic                        MOTOR_SET_TWO,
  output logic [FREQ_W-1:0]           SET_FREQ,
  output logic                        FREQ_HOLD,
  output logic                        MAIN_PRESET,
  output logic                        AUX_PRESET,
  // Modes
  output logic [1:0]                  CMD_SOURCE,
  output logic                        TORQUE_MODE,
  output logic [1:0]                  WIRE_MODE,
  output dif_pid_s                    PID_CTRL
);

  localparam int CNT_W = 28;

  typedef enum logic [1:0] {BRK_IDLE, BRK_DECEL, BRK_HOLD} dif_brk_e;

  logic [N-1:0]     level;
  logic [CNT_W-1:0] threshold_r;
  logic [15:0]      step_val;
  logic [3:0]       step_idx_nxt;
  logic             pause_prev_r;
  logic             was_running_r;
  logic             flt_no_prev_r;
  logic             flt_nc_prev_r;
  logic             uf1_prev_r;
  logic             uf2_prev_r;
  dif_brk_e         brk_r;
  dif_brk_e         brk_nxt;

  // True when any input assigned to the code is active; codes with no
  // decode below never match anything, so reserved codes stay inert
  function automatic logic fn_on(input dif_code_t code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N; i++)
      if (level[i] && (FUNC_SEL[i] == code) && (code != 6'h00))
        hit = 1'b1; // R25
    return hit;
  endfunction

  // True when any input carries the code, whatever its level
  function automatic logic fn_assigned(input dif_code_t code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N; i++)
      if (FUNC_SEL[i] == code)
        hit = 1'b1;
    return hit;
  endfunction

  // Filter threshold registered so the multiplier stays off the filter path
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      threshold_r <= CNT_W'(DIF_FILTER_DEF_MS * CYCLES_PER_MS);
    else
      threshold_r <= CNT_W'(INPUT_FILTER_TIME * CYCLES_PER_MS); // R24
  end

  dif_in_filter #(
    .N     (N),
    .CNT_W (CNT_W)
  ) u_filter (
    .clk       (CORE_CLK),
    .srst      (SRST),
    .pins      (DIGITAL_INPUT_TERMINAL),
    .threshold (threshold_r),
    .level     (level)
  );

  // Step index from the four step terminals; a process, not an assign, so
  // that it wakes on the filtered levels the function reads
  always_comb
  begin
    step_idx_nxt = {fn_on(FN_STEP_B3), fn_on(FN_STEP_B2),
                    fn_on(FN_STEP_B1), fn_on(FN_STEP_B0)}; // R04
  end

  dif_step_mem #(
    .W (16)
  ) u_steps (
    .clk     (CORE_CLK),
    .wr_en   (STEP_WR_EN),
    .wr_addr (STEP_WR_ADDR),
    .wr_data (STEP_WR_DATA),
    .rd_addr (STEP_INDEX),
    .rd_data (step_val)
  );

  // Step scaling; constant divide traded for one full cycle of slack
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      STEP_INDEX <= 4'h0;
      STEP_FREQ  <= '0;
    end
    else
    begin
      STEP_INDEX <= step_idx_nxt;
      if (FREQ_SRC_MULTISTEP)
        STEP_FREQ <= FREQ_W'((32'(step_val) * 32'(MAXIMUM_FREQUENCY_SETTING))
                             / 32'(DIF_STEP_FULL_SCALE)); // R05
      else
        STEP_FREQ <= '0;
    end
  end

  // Stop requests are plain levels that follow the filtered inputs
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      OUTPUT_DISABLE <= 1'b0;
      PAUSE_STOP_REQ <= 1'b0;
      STOP_DECEL_REQ <= 1'b0;
      FREQ_HOLD      <= 1'b0;
    end
    else
    begin
      OUTPUT_DISABLE <= fn_on(FN_COAST); // R01
      PAUSE_STOP_REQ <= fn_on(FN_RUN_PAUSE); // R02
      STOP_DECEL_REQ <= fn_on(FN_EXT_STOP2); // R21
      FREQ_HOLD      <= fn_on(FN_RAMP_INH) && !STOP_CMD; // R09
    end
  end

  // Remember whether the drive ran when the pause began
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      pause_prev_r  <= 1'b0;
      was_running_r <= 1'b0;
      RESUME_REQ    <= 1'b0;
    end
    else
    begin
      pause_prev_r <= fn_on(FN_RUN_PAUSE);
      if (fn_on(FN_RUN_PAUSE) && !pause_prev_r)
        was_running_r <= RUNNING;
      RESUME_REQ <= pause_prev_r && !fn_on(FN_RUN_PAUSE) && was_running_r; // R02
    end
  end

  // Fault events fire on the rising edge of each fault function;
  // the stopping fault wins when two arrive together
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      flt_no_prev_r <= 1'b0;
      flt_nc_prev_r <= 1'b0;
      uf1_prev_r    <= 1'b0;
      uf2_prev_r    <= 1'b0;
      FAULT_RAISE   <= 1'b0;
      FAULT         <= '{code: DIF_RST_CODE, action: 2'h0};
    end
    else
    begin
      flt_no_prev_r <= fn_on(FN_EXT_FLT_NO);
      flt_nc_prev_r <= fn_on(FN_EXT_FLT_NC);
      uf1_prev_r    <= fn_on(FN_USER_FLT1);
      uf2_prev_r    <= fn_on(FN_USER_FLT2);
      FAULT_RAISE   <= 1'b1;
      if (fn_on(FN_EXT_FLT_NC) && !flt_nc_prev_r)
        FAULT <= '{code: EXTERNAL_FAULT_CODE, action: DIF_ACT_STOP}; // R12
      else if (fn_on(FN_EXT_FLT_NO) && !flt_no_prev_r)
        FAULT <= '{code: EXTERNAL_FAULT_CODE, action: EXT_FAULT_RESPONSE}; // R03
      else if (fn_on(FN_USER_FLT1) && !uf1_prev_r)
        FAULT <= '{code: USER_FAULT_ONE_CODE, action: USER_FAULT_RESPONSE_SETTING}; // R19
      else if (fn_on(FN_USER_FLT2) && !uf2_prev_r)
        FAULT <= '{code: USER_FAULT_TWO_CODE, action: USER_FAULT_RESPONSE_SETTING}; // R19
      else
        FAULT_RAISE <= 1'b0;
    end
  end

  // Ramp pair: stop 2 forces the fourth pair, motor select overrides the pins
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      RAMP_SEL      <= 2'h0;
      MOTOR_SET_TWO <= 1'b0;
    end
    else
    begin
      MOTOR_SET_TWO <= fn_on(FN_MOTOR_SEL); // R17
      if (fn_on(FN_EXT_STOP2))
        RAMP_SEL <= DIF_RAMP_FOURTH; // R21
      else if (fn_assigned(FN_MOTOR_SEL))
        RAMP_SEL <= {1'b0, fn_on(FN_MOTOR_SEL)}; // R17
      else
        RAMP_SEL <= {fn_on(FN_RAMP_B1), fn_on(FN_RAMP_B0)}; // R06
    end
  end

  // Set frequency; the lock also blocks the clear, which is a change too
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      SET_FREQ <= '0;
    else if (fn_on(FN_FREQ_LOCK))
      SET_FREQ <= SET_FREQ; // R13
    else if (fn_on(FN_UD_CLEAR))
      SET_FREQ <= PRESET_FREQUENCY_SETTING; // R07
    else if (FREQ_MOD_REQ)
      SET_FREQ <= FREQ_MOD_VALUE;
  end

  // Preset overrides, command source, control and wire modes
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      MAIN_PRESET <= 1'b0;
      AUX_PRESET  <= 1'b0;
      CMD_SOURCE  <= DIF_SRC_TERMINAL;
      TORQUE_MODE <= DIF_MODE_SPEED;
      WIRE_MODE   <= DIF_WIRE2_MODE1;
    end
    else
    begin
      MAIN_PRESET <= fn_on(FN_MAIN_PRE); // R16
      AUX_PRESET  <= fn_on(FN_AUX_PRE); // R16
      if (fn_on(FN_SRC_KEYPAD))
        CMD_SOURCE <= DIF_SRC_KEYPAD; // R08
      else if (fn_on(FN_SRC_COMM) && (CMD_SOURCE_SETTING == DIF_SRC_TERMINAL))
        CMD_SOURCE <= DIF_SRC_COMM; // R14
      else
        CMD_SOURCE <= CMD_SOURCE_SETTING;
      if (fn_on(FN_TQ_INHIBIT))
        TORQUE_MODE <= DIF_MODE_SPEED; // R11
      else
        TORQUE_MODE <= CONTROL_MODE_SETTING ^ fn_on(FN_SPD_TQ); // R20
      if (fn_on(FN_WIRE_SWAP) && (TERMINAL_COMMAND_MODE == DIF_WIRE2_MODE1))
        WIRE_MODE <= DIF_WIRE3_MODE1; // R23
      else
        WIRE_MODE <= TERMINAL_COMMAND_MODE;
    end
  end

  // PID controls
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      PID_CTRL <= '0;
    else
    begin
      PID_CTRL.pause    <= fn_on(FN_PID_PAUSE); // R10
      PID_CTRL.int_hold <= fn_on(FN_INT_HOLD); // R15
      PID_CTRL.gain_two <= (PID_GAIN_SWITCH_SOURCE == DIF_GAIN_BY_TERM) && fn_on(FN_PID_GAIN); // R18
      PID_CTRL.dir_rev  <= PID_DIRECTION_SETTING ^ fn_on(FN_PID_REV);
    end
  end

  // Decelerate-then-brake sequence; dropping the input aborts it
  always_comb
  begin
    brk_nxt = brk_r;
    case (brk_r)
      BRK_IDLE:
        if (fn_on(FN_DEC_BRAKE))
          brk_nxt = BRK_DECEL;
      BRK_DECEL:
        if (!fn_on(FN_DEC_BRAKE))
          brk_nxt = BRK_IDLE;
        else if (OUT_FREQ <= DC_START_FREQ)
          brk_nxt = BRK_HOLD; // R22
      BRK_HOLD:
        if (!fn_on(FN_DEC_BRAKE))
          brk_nxt = BRK_IDLE;
      default:
        brk_nxt = BRK_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      brk_r           <= BRK_IDLE;
      BRAKE_DECEL_REQ <= 1'b0;
      DC_BRAKE_ON     <= 1'b0;
    end
    else
    begin
      brk_r           <= brk_nxt;
      BRAKE_DECEL_REQ <= (brk_nxt == BRK_DECEL); // R22
      DC_BRAKE_ON     <= (brk_nxt == BRK_HOLD); // R22
    end
  end

  // Checks watch a plain vector, since a function body is not sampled
  logic [63:0] fn_act;
  always_comb
  begin
    for (int k = 0; k < 64; k++)
      fn_act[k] = fn_on(6'(k));
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  coast_follows_a: assert property (fn_act[FN_COAST] |=> OUTPUT_DISABLE) // R01
    else $error("coast stop did not disable output");
  pause_resume_a: assert property ($fell(fn_act[FN_RUN_PAUSE]) && was_running_r |=> RESUME_REQ) // R02
    else $error("pause release did not resume");
  fault_no_a: assert property ($rose(fn_act[FN_EXT_FLT_NO]) && !$rose(fn_act[FN_EXT_FLT_NC])
                               |=> FAULT_RAISE && FAULT.code == EXTERNAL_FAULT_CODE) // R03
    else $error("open contact fault not raised");
  step_index_a: assert property (##1 STEP_INDEX == $past({fn_act[FN_STEP_B3], fn_act[FN_STEP_B2],
                                                          fn_act[FN_STEP_B1], fn_act[FN_STEP_B0]})) // R04
    else $error("step index wrong");
  ramp_stop2_a: assert property (fn_act[FN_EXT_STOP2] |=> RAMP_SEL == 2'h3 && STOP_DECEL_REQ) // R21
    else $error("stop 2 not on fourth ramp");
  clear_preset_a: assert property (fn_act[FN_UD_CLEAR] && !fn_act[FN_FREQ_LOCK]
                                   |=> SET_FREQ == $past(PRESET_FREQUENCY_SETTING)) // R07
    else $error("clear did not restore preset");
  keypad_src_a: assert property (fn_act[FN_SRC_KEYPAD] |=> CMD_SOURCE == DIF_SRC_KEYPAD) // R08
    else $error("keypad source not taken");
  hold_stop_a: assert property (STOP_CMD |=> !FREQ_HOLD) // R09
    else $error("hold blocked a stop");
  lock_freq_a: assert property (fn_act[FN_FREQ_LOCK] |=> $stable(SET_FREQ)) // R13
    else $error("locked frequency changed");
  tq_inhibit_a: assert property (fn_act[FN_TQ_INHIBIT] |=> TORQUE_MODE == DIF_MODE_SPEED) // R11
    else $error("torque mode while inhibited");
  user_flt_a: assert property ($rose(fn_act[FN_USER_FLT2]) && !$rose(fn_act[FN_USER_FLT1])
                               && !$rose(fn_act[FN_EXT_FLT_NO]) && !$rose(fn_act[FN_EXT_FLT_NC])
                               |=> FAULT.code == USER_FAULT_TWO_CODE) // R19
    else $error("user fault two code wrong");
  brake_seq_a: assert property (DC_BRAKE_ON |-> $past(BRAKE_DECEL_REQ) || $past(DC_BRAKE_ON)) // R22
    else $error("DC brake without deceleration");

  pause_cycle_c: cover property ($rose(PAUSE_STOP_REQ) ##[1:50] RESUME_REQ);
  brake_cycle_c: cover property (BRAKE_DECEL_REQ ##[1:50] DC_BRAKE_ON);
  fault_event_c: cover property (FAULT_RAISE && FAULT.action == DIF_ACT_STOP);

endmodule

// ---- hw/dif_pkg.sv ----
// Shared constants, codes and carrier types of the input function decoder
package dif_pkg;

  // Terminal function codes
  typedef logic [5:0] dif_code_t;
  localparam dif_code_t FN_COAST      = 6'h08;
  localparam dif_code_t FN_RUN_PAUSE  = 6'h0a;
  localparam dif_code_t FN_EXT_FLT_NO = 6'h0b;
  localparam dif_code_t FN_STEP_B0    = 6'h0c;
  localparam dif_code_t FN_STEP_B1    = 6'h0d;
  localparam dif_code_t FN_STEP_B2    = 6'h0e;
  localparam dif_code_t FN_STEP_B3    = 6'h0f;
  localparam dif_code_t FN_RAMP_B0    = 6'h10;
  localparam dif_code_t FN_RAMP_B1    = 6'h11;
  localparam dif_code_t FN_UD_CLEAR   = 6'h13;
  localparam dif_code_t FN_SRC_KEYPAD = 6'h14;
  localparam dif_code_t FN_RAMP_INH   = 6'h15;
  localparam dif_code_t FN_PID_PAUSE  = 6'h16;
  localparam dif_code_t FN_TQ_INHIBIT = 6'h1d;
  localparam dif_code_t FN_EXT_FLT_NC = 6'h21;
  localparam dif_code_t FN_FREQ_LOCK  = 6'h22;
  localparam dif_code_t FN_PID_REV    = 6'h23;
  localparam dif_code_t FN_SRC_COMM   = 6'h25;
  localparam dif_code_t FN_INT_HOLD   = 6'h26;
  localparam dif_code_t FN_MAIN_PRE   = 6'h27;
  localparam dif_code_t FN_AUX_PRE    = 6'h28;
  localparam dif_code_t FN_MOTOR_SEL  = 6'h29;
  localparam dif_code_t FN_PID_GAIN   = 6'h2b;
  localparam dif_code_t FN_USER_FLT1  = 6'h2c;
  localparam dif_code_t FN_USER_FLT2  = 6'h2d;
  localparam dif_code_t FN_SPD_TQ     = 6'h2e;
  localparam dif_code_t FN_EXT_STOP2  = 6'h30;
  localparam dif_code_t FN_DEC_BRAKE  = 6'h31;
  localparam dif_code_t FN_WIRE_SWAP  = 6'h33;

  // Fault codes and protection actions
  localparam logic [7:0] EXTERNAL_FAULT_CODE = 8'h0f;
  localparam logic [7:0] USER_FAULT_ONE_CODE = 8'h1b;
  localparam logic [7:0] USER_FAULT_TWO_CODE = 8'h1c;
  localparam logic [1:0] DIF_ACT_STOP        = 2'h1;

  // Command sources, wire modes, control modes
  localparam logic [1:0] DIF_SRC_KEYPAD   = 2'h0;
  localparam logic [1:0] DIF_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] DIF_SRC_COMM     = 2'h2;
  localparam logic [1:0] DIF_WIRE2_MODE1  = 2'h0;
  localparam logic [1:0] DIF_WIRE3_MODE1  = 2'h2;
  localparam logic       DIF_MODE_SPEED   = 1'b0;
  localparam logic [1:0] DIF_GAIN_BY_TERM = 2'h1;
  localparam logic [1:0] DIF_RAMP_FOURTH  = 2'h3;

  // Step scaling: step values in 0.1 % units, 1000 is 100 %
  localparam logic [15:0] DIF_STEP_FULL_SCALE = 16'h03e8;
  localparam logic [7:0]  DIF_RST_CODE        = 8'h00;

  // Filter timing
  localparam int          DIF_CLK_PERIOD_NS   = 4;
  localparam int          DIF_NS_PER_MS       = 1000000;
  localparam int          DIF_CYCLES_PER_MS   = (DIF_NS_PER_MS + DIF_CLK_PERIOD_NS - 1) / DIF_CLK_PERIOD_NS;
  localparam logic [9:0]  DIF_FILTER_DEF_MS   = 10'h00a;

  // Carriers
  typedef struct packed {
    logic pause;
    logic int_hold;
    logic gain_two;
    logic dir_rev;
  } dif_pid_s;

  typedef struct packed {
    logic [7:0] code;
    logic [1:0] action;
  } dif_fault_s;

endpackage

// ---- hw/dif_in_filter.sv ----
// Pin synchroniser and stability filter for the input terminals
`timescale 1ns/1ps
module dif_in_filter
  import dif_pkg::*;
#(
  parameter int N     = 7,
  parameter int CNT_W = 28
)(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [N-1:0]     pins,
  input  wire logic [CNT_W-1:0] threshold,
  output logic      [N-1:0]     level
);

  for (genvar i = 0; i < N; i++)
  begin : g_in
    logic             s1_r;
    logic             s2_r;
    logic             s3_r;
    logic [CNT_W-1:0] cnt_r;

    // Three stages; only the last two are compared
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end
      else
      begin
        s1_r <= pins[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    // Level changes only after staying put for the whole threshold
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        cnt_r    <= '0;
        level[i] <= 1'b0;
      end
      else if ((s2_r != s3_r) || (s3_r == level[i]))
        cnt_r <= '0;
      else if (cnt_r >= threshold)
      begin
        level[i] <= s3_r; // R24
        cnt_r    <= '0;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

// ---- hw/dif_step_mem.sv ----
// Sixteen stored step references with registered read
`timescale 1ns/1ps
module dif_step_mem
#(
  parameter int W = 16
)(
  input  wire logic         clk,
  input  wire logic         wr_en,
  input  wire logic [3:0]   wr_addr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [3:0]   rd_addr,
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] mem [16];

  // Plain array, so it maps onto distributed memory
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- tb/dif_contact_model.sv ----
// Switch contact model on one input terminal, with chatter after each change
`timescale 1ns/1ps
module dif_contact_model
(
  // Clock
  input  wire logic       clk,
  // Commanded contact state and chatter length
  input  wire logic       want,
  input  wire logic [3:0] chatter,
  // Terminal pin
  output logic            pin
);
  logic       want_r = 1'b0;
  logic [3:0] left_r = 4'h0;
  initial pin = 1'b0;
  // Contact bounces after each change, so the filter has to ride it out
  always @(posedge clk)
  begin
    want_r <= want;
    if (want != want_r)
      left_r <= chatter;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
    pin <= (left_r != 4'h0) ? ~pin : want;
  end
endmodule

// ---- tb/dif_tb.sv ----
// Self-checking bench for the input function decoder
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("FAIL %0t %s", $time, m); end end
module tb
  import dif_pkg::*;
;
  localparam int N = 7;
  logic clk = 1'b0, srst = 1'b1, strobe = 1'b0, mod_req = 1'b0, wr_en = 1'b0;
  logic ctl = 1'b0, pdir = 1'b0, multi = 1'b0, run = 1'b1, stop = 1'b0;
  logic [N-1:0] want = '0, pins;
  logic [N-1:0][5:0] fsel = '0;
  logic [3:0] chat = 4'h0, wr_a = 4'h0, sidx;
  logic [1:0] src = 2'h1, wmode = 2'h0, gsrc = 2'h0, eact = 2'h0, uact = 2'h0;
  logic [9:0] filt = 10'h002;
  logic [15:0] max_f = '0, pre_f = '0, dc_f = '0, out_f = '0, mod_v = '0, wr_d = '0, set_exp = '0;
  logic [15:0] mem [16];
  logic od, psr, resume, sdr, bdr, dcb, fr, mset2, fhold, mpre, apre, tmode;
  logic [15:0] sfreq, setf;
  logic [1:0] rsel, csrc, wm;
  dif_fault_s flt;
  dif_pid_s pid;
  logic [55:0] snap_q [$];
  logic [11:0] evt_q [$];
  integer seed = 32'ha4dee5b7;
  int bad_count = 0, samples_checked = 0;
  initial forever #2 clk = ~clk;
  // Chattering contacts on every terminal
  for (genvar k = 0; k < N; k++)
  begin : g_contact
    dif_contact_model i_dif_contact_model (.clk(clk), .want(want[k]), .chatter(chat), .pin(pins[k]));
  end
  dif_decoder #(.N(N), .FREQ_W(16), .CYCLES_PER_MS(2)) i_dif_decoder (.CORE_CLK(clk), .SRST(srst),
    .DIGITAL_INPUT_TERMINAL(pins), .FUNC_SEL(fsel), .INPUT_FILTER_TIME(filt), .CMD_SOURCE_SETTING(src),
    .TERMINAL_COMMAND_MODE(wmode), .CONTROL_MODE_SETTING(ctl), .PID_DIRECTION_SETTING(pdir),
    .PID_GAIN_SWITCH_SOURCE(gsrc), .EXT_FAULT_RESPONSE(eact), .USER_FAULT_RESPONSE_SETTING(uact),
    .FREQ_SRC_MULTISTEP(multi), .MAXIMUM_FREQUENCY_SETTING(max_f), .PRESET_FREQUENCY_SETTING(pre_f),
    .DC_START_FREQ(dc_f), .STEP_WR_EN(wr_en), .STEP_WR_ADDR(wr_a), .STEP_WR_DATA(wr_d), .RUNNING(run),
    .STOP_CMD(stop), .OUT_FREQ(out_f), .FREQ_MOD_REQ(mod_req), .FREQ_MOD_VALUE(mod_v),
    .OUTPUT_DISABLE(od), .PAUSE_STOP_REQ(psr), .RESUME_REQ(resume), .STOP_DECEL_REQ(sdr),
    .BRAKE_DECEL_REQ(bdr), .DC_BRAKE_ON(dcb), .FAULT_RAISE(fr), .FAULT(flt), .STEP_INDEX(sidx),
    .STEP_FREQ(sfreq), .RAMP_SEL(rsel), .MOTOR_SET_TWO(mset2), .SET_FREQ(setf), .FREQ_HOLD(fhold),
    .MAIN_PRESET(mpre), .AUX_PRESET(apre), .CMD_SOURCE(csrc), .TORQUE_MODE(tmode), .WIRE_MODE(wm),
    .PID_CTRL(pid));
  // Expected outputs for one terminal with code c at level l, all others unassigned
  function automatic logic [55:0] exp_snap(input logic [5:0] c, input logic l);
    logic [1:0] cs, rs;
    logic [3:0] si;
    logic dc;
    logic [31:0] sf;
    cs = (l && c == FN_SRC_KEYPAD) ? DIF_SRC_KEYPAD :
         (l && c == FN_SRC_COMM && src == DIF_SRC_TERMINAL) ? DIF_SRC_COMM : src;
    si = (l && c >= FN_STEP_B0 && c <= FN_STEP_B3) ? 4'h1 << (c - FN_STEP_B0) : 4'h0;
    rs = (l && c == FN_EXT_STOP2) ? DIF_RAMP_FOURTH : (c == FN_MOTOR_SEL) ? {1'b0, l} :
         (l && c == FN_RAMP_B0) ? 2'h1 : (l && c == FN_RAMP_B1) ? 2'h2 : 2'h0;
    dc = l && c == FN_DEC_BRAKE && out_f <= dc_f;
    sf = multi ? 32'(mem[si]) * 32'(max_f) / 32'(DIF_STEP_FULL_SCALE) : 32'h0;
    return {l && c == FN_COAST, l && c == FN_RUN_PAUSE, l && c == FN_EXT_STOP2, l && c == FN_RAMP_INH && !stop,
            l && c == FN_MAIN_PRE, l && c == FN_AUX_PRE, l && c == FN_MOTOR_SEL, l && c == FN_DEC_BRAKE && !dc,
            dc, cs, (ctl ^ (l && c == FN_SPD_TQ)) && !(l && c == FN_TQ_INHIBIT),
            (l && c == FN_WIRE_SWAP && wmode == DIF_WIRE2_MODE1) ? DIF_WIRE3_MODE1 : wmode,
            l && c == FN_PID_PAUSE, l && c == FN_INT_HOLD, l && c == FN_PID_GAIN && gsrc == DIF_GAIN_BY_TERM,
            pdir ^ (l && c == FN_PID_REV), rs, si, set_exp, sf[15:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [5:0] c, input logic l);
    snap_q.push_back(exp_snap(c, l));
    strobe <= 1'b1;
    tick(1);
    strobe <= 1'b0;
  endtask
  // One set frequency change request; lock ignores it, clear overrides it
  task automatic modify(input logic [5:0] c, input logic l);
    mod_v <= 16'($random(seed));
    mod_req <= 1'b1;
    tick(1);
    mod_req <= 1'b0;
    if (!(l && c == FN_FREQ_LOCK))
      set_exp = (l && c == FN_UD_CLEAR) ? pre_f : mod_v;
    tick(4);
    check(c, l);
  endtask
  task automatic results;
    if (snap_q.size() != 0 || evt_q.size() != 0)
      bad_count++;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Level outputs compared against the oldest note at each strobe
  always @(posedge clk)
  begin
    if (strobe)
      `CHK({od, psr, sdr, fhold, mpre, apre, mset2, bdr, dcb, csrc, tmode, wm, pid, rsel, sidx, setf, sfreq},
           snap_q.pop_front(), "level outputs")
  end
  // Fault and resume pulses; an unexpected pulse is a mismatch
  always @(posedge clk)
  begin
    if (fr === 1'b1 || resume === 1'b1)
    begin
      if (evt_q.size() == 0)
        `CHK(1'b1, 1'b0, "unexpected pulse")
      else
        `CHK(fr ? {2'd1, flt} : {2'd2, 10'h0}, evt_q.pop_front(), "pulse")
    end
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end
  initial
  begin
    logic [5:0] c;
    logic [N-1:0][5:0] fs;
    int t;
    tick(10);
    check(6'h00, 1'b0);
    tick(1);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++)
    begin
      mem[a] = 16'($unsigned($random(seed)) % 1001);
      wr_a <= 4'(a);
      wr_d <= mem[a];
      wr_en <= 1'b1;
      tick(1);
    end
    wr_en <= 1'b0;
    // Every function code, reserved ones included, on a rotating terminal
    for (int i = 0; i < 64; i++)
    begin
      c = 6'(i);
      t = i % N;
      want <= 7'($random(seed)) & ~(7'h01 << t);
      fsel <= '0; // Old code off first, so a random level on its pin stays inert
      {ctl, pdir, multi, run, stop, wmode, gsrc, eact, uact, chat} <= 17'($random(seed)) & 17'h1fff3;
      filt <= {9'h001, 1'($random(seed))};
      src <= 2'($unsigned($random(seed)) % 3);
      {max_f, pre_f, dc_f, out_f} <= {$random(seed), $random(seed)};
      tick(24);
      fs = '0;
      fs[t] = c;
      fsel <= fs;
      tick(24);
      modify(c, 1'b0);
      case (c)
        FN_EXT_FLT_NO: evt_q.push_back({2'd1, EXTERNAL_FAULT_CODE, eact});
        FN_EXT_FLT_NC: evt_q.push_back({2'd1, EXTERNAL_FAULT_CODE, DIF_ACT_STOP});
        FN_USER_FLT1:  evt_q.push_back({2'd1, USER_FAULT_ONE_CODE, uact});
        FN_USER_FLT2:  evt_q.push_back({2'd1, USER_FAULT_TWO_CODE, uact});
        default: ;
      endcase
      want[t] <= 1'b1;
      tick(24);
      modify(c, 1'b1);
      if (c == FN_RUN_PAUSE && run)
        evt_q.push_back({2'd2, 10'h0});
      want[t] <= 1'b0;
      tick(24);
      check(c, 1'b0);
      // A pulse shorter than the filter must leave everything alone
      chat <= 4'h0;
      tick(1);
      want[t] <= 1'b1;
      tick(2);
      want[t] <= 1'b0;
      tick(24);
      check(c, 1'b0);
    end
    tick(8);
    results();
  end
endmodule
